/* File: dv/host_apb_model.sv */
// Host processor model: single APB transfers issued on request of the bench.
// Assumes one pclk domain; the bench bounds every wait for pready.
`timescale 1ns/1ns
module host_apb_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // A flags read, or a write clearing the thermistor mode or VIN_MON enable bit, lets thermistor or supply forced torch or off resume
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : host_apb_model

/* File: dv/testbench.sv */
// Self-checking bench for the flag and mode block, driven through the host model.
// Assumes the designer's latencies: flags set one edge after cause, drive one edge later.
`timescale 1ns/1ns
`include "flag_ctrl_map.svh"
module testbench;
    localparam int TO_CYC = 4500;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hardware_enable_pin = 1'b1;
    logic strobe_pin = 1'b0;
    logic pa_sync_input_one = 1'b0;
    logic voltage_mode_pin = 1'b0;
    flag_ctrl_pkg::analog_status_s analog = '0;
    flag_ctrl_pkg::drive_ctrl_s drive;
    logic [31:0] v;
    logic e;
    logic [3:0] lvl;
    logic [3:0] l0;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] ad [7] = '{`ADDR_VIN_MON, `ADDR_TORCH, `ADDR_FLASH, `ADDR_TIMING,
                           `ADDR_FLAGS, `ADDR_CFG1, `ADDR_CFG2};
    logic [7:0] rv [7] = '{`RST_VIN_MON, `RST_TORCH, `RST_FLASH, `RST_TIMING,
                           `RST_FLAGS, `RST_CFG1, `RST_CFG2};
    wire [2:0] vo = {drive.voltage_output_select, drive.output_level_select,
                     drive.light_load_enable};

    always #4 pclk = ~pclk;

    host_apb_model host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                           .pready, .pslverr);
    fault_flag_and_mode_control #(.SHORT_QUAL_CYCLES(20), .FLASH_TIMEOUT_CYCLES(TO_CYC)) dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .hardware_enable_pin, .strobe_pin, .pa_sync_input_one,
        .voltage_mode_pin, .analog, .drive);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] fv(input logic [3:0] l, input logic [1:0] en);
        return {1'b0, l, 1'b0, en};
    endfunction : fv

    function automatic logic [31:0] fl(input int b);
        return 32'h1 << b;
    endfunction : fl

    task automatic conclude();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer(1'b1, a, d, v, e);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        host_u.xfer(1'b0, a, 8'h00, v, e);
    endtask : rd

    task automatic rf(input logic [31:0] exp);
        rd(`ADDR_FLAGS);
        chk(v, exp);
    endtask : rf

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // Long flashes dominate the run; the ceiling leaves about twice their sum
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            conclude();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h3b3d));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(ad[i]);
            chk(v, {24'h0, rv[i]});
        end
        rd(8'h10);
        chk({v[30:0], e}, 32'h1);
        pa_sync_input_one <= 1'b1;
        cyc(3);
        pa_sync_input_one <= 1'b0;
        rf(fl(`FLG_SYNC1));
        fork
            rf(32'h0);
            begin
                cyc(2);
                pa_sync_input_one <= 1'b1;
            end
        join
        rf(fl(`FLG_SYNC1));
        pa_sync_input_one <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            voltage_mode_pin <= !p[0];
            wr(`ADDR_CFG1, {1'b0, p[0], 6'h20});
            cyc(3);
            rd(`ADDR_FLAGS);
            voltage_mode_pin <= p[0];
            cyc(3);
            rf(fl(`FLG_SYNC2));
            voltage_mode_pin <= !p[0];
            cyc(3);
            rf(32'h0);
        end
        voltage_mode_pin <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(`ADDR_CFG1, {6'h10, k[1:0]});
            wr(`ADDR_TORCH, 8'h54);
            cyc(5);
            chk({29'h0, vo}, {29'h0, 1'b1, k[1], !k[0]});
        end
        wr(`ADDR_CFG1, 8'h42);
        wr(`ADDR_TORCH, 8'h50);
        voltage_mode_pin <= 1'b1;
        cyc(5);
        chk({29'h0, vo}, 32'h7);
        voltage_mode_pin <= 1'b0;
        cyc(5);
        chk({29'h0, vo}, 32'h2);
        lvl = 4'($urandom_range(15, 8));
        wr(`ADDR_FLASH, fv(lvl, 2'b11));
        cyc(1000);
        l0 = drive.led_level;
        chk({30'h0, drive.led_drive_on, drive.light_load_enable}, 32'h2);
        cyc(2000);
        chk({28'h0, drive.led_level}, {28'h0, l0 + 4'h1});
        cyc(TO_CYC - 2900);
        rf(fl(`FLG_TIMEOUT));
        rd(`ADDR_TORCH);
        chk(v, {24'h0, `RST_TORCH});
        wr(`ADDR_FLASH, fv(lvl, 2'b11));
        cyc(TO_CYC + 100);
        wr(`ADDR_FLASH, fv(lvl, 2'b11));
        rf(32'h0);
        wr(`ADDR_FLASH, fv(lvl, 2'b00));
        cyc(TO_CYC + 100);
        rf(32'h0);
        strobe_pin <= 1'b1;
        cyc(20);
        chk({31'h0, drive.led_drive_on}, 32'h1);
        strobe_pin <= 1'b0;
        cyc(5);
        chk({31'h0, drive.led_drive_on}, 32'h0);
        analog.overvoltage_trip <= 1'b1;
        cyc(300);
        analog.overvoltage_trip <= 1'b0;
        rf(32'h0);
        wr(`ADDR_FLASH, fv(lvl, 2'b11));
        analog.overvoltage_trip <= 1'b1;
        cyc(260);
        analog.overvoltage_trip <= 1'b0;
        rf(fl(`FLG_LED_FAULT_FLAG));
        analog.led_short_two <= 1'b1;
        cyc(25);
        analog.led_short_two <= 1'b0;
        rf(fl(`FLG_LED_FAULT_FLAG));
        rf(32'h0);
        for (int j = 0; j < 2; j++) begin
            analog.over_temp_hot <= 1'b1;
            cyc(5);
            chk({30'h0, drive.boost_enable, drive.led_drive_on}, 32'h0);
            analog.over_temp_hot <= 1'b0;
            analog.over_temp_cool <= 1'b1;
            cyc(5);
            chk({31'h0, drive.led_drive_on}, 32'h1);
            analog.over_temp_cool <= 1'b0;
        end
        rf(fl(`FLG_OVT));
        wr(`ADDR_CFG1, 8'h4a);
        wr(`ADDR_VIN_MON, 8'hf1);
        analog.thermistor_below_ref <= 1'b1;
        analog.vin_below_threshold <= 1'b1;
        cyc(3);
        analog.thermistor_below_ref <= 1'b0;
        analog.vin_below_threshold <= 1'b0;
        rf(fl(`FLG_THERM) | fl(`FLG_VIN));
        wr(`ADDR_FLASH, fv(lvl, 2'b00));
        pa_sync_input_one <= 1'b1;
        cyc(3);
        hardware_enable_pin <= 1'b0;
        pa_sync_input_one <= 1'b0;
        cyc(3);
        hardware_enable_pin <= 1'b1;
        rf({24'h0, `RST_FLAGS});
        rd(`ADDR_CFG1);
        chk(v, {24'h0, `RST_CFG1});
        wr(`ADDR_TORCH, 8'h51);
        cyc(3);
        chk({31'h0, drive.indicator_driver}, 32'h1);
        analog.over_temp_hot <= 1'b1;
        cyc(3);
        chk({31'h0, drive.indicator_driver}, 32'h0);
        analog.over_temp_hot <= 1'b0;
        rf(fl(`FLG_OVT));
        conclude();
    end
endmodule : testbench

/* File: hdl/fault_flag_and_mode_control.sv */
// Fault flags, sync-input events and flash/torch/voltage mode control behind an APB slave.
// Assumes all pin and comparator inputs are synchronous to pclk.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "flag_ctrl_map.svh"

module fault_flag_and_mode_control #(
    parameter int SHORT_QUAL_CYCLES = (`LED_SHORT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int FLASH_TIMEOUT_CYCLES = `FLASH_TIMEOUT_NS / `CLK_PERIOD_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hardware_enable_pin,
    input wire logic strobe_pin,
    input wire logic pa_sync_input_one,
    // Shared pin: sync input two in sync mode, voltage-mode request otherwise
    input wire logic voltage_mode_pin,
    input wire flag_ctrl_pkg::analog_status_s analog,
    output flag_ctrl_pkg::drive_ctrl_s drive
);

    localparam int OPEN_CYCLES = (`LED_OPEN_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int STEP_CYCLES = (`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    function automatic logic [31:0] cnt_next(input logic [31:0] c, input logic run);
        cnt_next = run ? c + 32'h1 : 32'h0;
    endfunction : cnt_next

    // ****************************************
    // APB decode
    // ****************************************
    logic [7:0] torch_reg, flash_reg, timing_reg, flags, cfg1, cfg2, vin_mon;
    logic [2:0] mode;
    logic strobe_d, sync1_d, sync2_d;
    flag_ctrl_pkg::flash_state_e state;
    logic [31:0] open_cnt, short_cnt, step_cnt, tmo_cnt;
    logic [3:0] ramp_level;
    logic ot_shutdown;

    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire hit_torch = paddr == `ADDR_TORCH;
    wire hit_flash = paddr == `ADDR_FLASH;
    wire hit_flags = paddr == `ADDR_FLAGS;
    wire mapped = hit_torch | hit_flash | hit_flags | (paddr == `ADDR_TIMING)
                  | (paddr == `ADDR_CFG1) | (paddr == `ADDR_CFG2) | (paddr == `ADDR_VIN_MON);
    wire wr = access & pwrite & mapped;
    wire mode_wr = wr & (hit_torch | hit_flash);
    wire flags_rd = access & ~pwrite & hit_flags;
    wire hw_off = ~hardware_enable_pin;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ****************************************
    // Mode and event decode
    // ****************************************
    wire sync1_mode = ~cfg1[`CFG1_HW_TORCH];
    wire sync2_mode = cfg1[`CFG1_SYNC2_MODE];
    wire therm_mode = cfg1[`CFG1_THERM_MODE];
    wire sync2_rise = voltage_mode_pin & ~sync2_d;
    wire sync2_fall = ~voltage_mode_pin & sync2_d;
    wire sync2_event = cfg1[`CFG1_SYNC2_POL] ? sync2_rise : sync2_fall;
    wire sync2_active = sync2_mode & (cfg1[`CFG1_SYNC2_POL] == voltage_mode_pin);
    wire strobe_rise = strobe_pin & ~strobe_d;
    wire strobe_fall = ~strobe_pin & strobe_d;
    wire flash_active = state != flag_ctrl_pkg::ST_IDLE;
    wire torch_mode = mode[1:0] == 2'h2;
    wire lit = flash_active | torch_mode;
    wire en_written_11 = mode_wr & (pwdata[1:0] == `EN_FLASH);
    wire flash_start = en_written_11 | (strobe_rise & ~flash_active);
    wire timeout_hit = flash_active & (tmo_cnt == 32'(FLASH_TIMEOUT_CYCLES - 1));
    // Early end: level strobe falling, or an enable bit written to zero
    wire flash_stop = (strobe_fall & ~flash_reg[`FLASH_TERM_SEL])
                      | (mode_wr & (pwdata[1:0] != `EN_FLASH));
    wire [3:0] target = flash_reg[`FLASH_LVL_MSB:`FLASH_LVL_LSB];

    // Thermistor and supply holds rely on the flag staying up until a read
    wire therm_force = flags[`FLG_THERM] & therm_mode;
    wire vin_force = flags[`FLG_VIN] & vin_mon[`VIN_MON_EN];
    wire sync_force = (sync2_active | (sync1_mode & pa_sync_input_one)) & flash_active;
    wire force_off = (therm_force & cfg2[`CFG2_THERM_OFF]) | (vin_force & cfg2[`CFG2_VIN_OFF])
                     | (sync2_active & flash_active & cfg2[`CFG2_SYNC2_OFF]);
    wire force_torch = therm_force | vin_force | sync_force;

    // ****************************************
    // Flag set and clear
    // ****************************************
    logic [7:0] flag_set, flag_clr;
    always_comb begin
        flag_set = 8'h00;
        flag_set[`FLG_TIMEOUT] = timeout_hit;
        flag_set[`FLG_OVT] = analog.over_temp_hot & ~ot_shutdown;
        flag_set[`FLG_LED_FAULT_FLAG] = (open_cnt == 32'(OPEN_CYCLES - 1))
                              | (short_cnt == 32'(SHORT_QUAL_CYCLES - 1));
        flag_set[`FLG_SYNC1] = sync1_mode & pa_sync_input_one & ~sync1_d;
        flag_set[`FLG_SYNC2] = sync2_mode & sync2_event;
        flag_set[`FLG_THERM] = lit & therm_mode & analog.thermistor_below_ref;
        flag_set[`FLG_VIN] = vin_mon[`VIN_MON_EN] & analog.vin_below_threshold;
        // Clear only what was returned, so events during the read survive
        flag_clr = flags_rd ? prdata[7:0] : 8'h00;
        flag_clr[`FLG_TIMEOUT] = flag_clr[`FLG_TIMEOUT] | flash_start;
    end

    wire [7:0] next_flags = (flags & ~flag_clr) | flag_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= `RST_FLAGS;
        end else if (hw_off) begin
            flags <= `RST_FLAGS;
        end else begin
            flags <= next_flags;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            torch_reg <= `RST_TORCH;
            flash_reg <= `RST_FLASH;
            timing_reg <= `RST_TIMING;
            cfg1 <= `RST_CFG1;
            cfg2 <= `RST_CFG2;
            vin_mon <= `RST_VIN_MON;
            mode <= 3'(`RST_TORCH);
        end else if (hw_off) begin
            torch_reg <= `RST_TORCH;
            flash_reg <= `RST_FLASH;
            timing_reg <= `RST_TIMING;
            cfg1 <= `RST_CFG1;
            cfg2 <= `RST_CFG2;
            vin_mon <= `RST_VIN_MON;
            mode <= 3'(`RST_TORCH);
        end else begin
            if (wr & hit_torch) torch_reg <= pwdata[7:0];
            if (wr & hit_flash) flash_reg <= pwdata[7:0];
            if (wr & (paddr == `ADDR_TIMING)) timing_reg <= pwdata[7:0];
            if (wr & (paddr == `ADDR_CFG1)) cfg1 <= pwdata[7:0];
            if (wr & (paddr == `ADDR_CFG2)) cfg2 <= pwdata[7:0];
            if (wr & (paddr == `ADDR_VIN_MON)) vin_mon <= pwdata[7:0];
            // The two brightness registers share one copy of the mode bits
            if (mode_wr) begin
                mode <= pwdata[`MODE_MSB:0];
            end else if (timeout_hit) begin
                mode <= 3'h0;
            end
        end
    end

    // Read data is latched in the setup phase; the flags snapshot doubles as the clear mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup & ~pwrite) begin
            case (paddr)
                `ADDR_TORCH: prdata <= {24'h0, torch_reg[7:3], mode};
                `ADDR_FLASH: prdata <= {24'h0, flash_reg[7:3], mode};
                `ADDR_TIMING: prdata <= {24'h0, timing_reg};
                `ADDR_FLAGS: prdata <= {24'h0, flags};
                `ADDR_CFG1: prdata <= {24'h0, cfg1};
                `ADDR_CFG2: prdata <= {24'h0, cfg2};
                `ADDR_VIN_MON: prdata <= {24'h0, vin_mon};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ****************************************
    // Edge history, thermal state, fault qualifiers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_d <= 1'b0;
            sync1_d <= 1'b0;
            sync2_d <= 1'b0;
            ot_shutdown <= 1'b0;
            open_cnt <= 32'h0;
            short_cnt <= 32'h0;
        end else begin
            strobe_d <= strobe_pin;
            sync1_d <= pa_sync_input_one;
            sync2_d <= voltage_mode_pin;
            if (analog.over_temp_hot) begin
                ot_shutdown <= 1'b1;
            end else if (analog.over_temp_cool) begin
                ot_shutdown <= 1'b0;
            end
            open_cnt <= cnt_next(open_cnt, lit & analog.overvoltage_trip);
            short_cnt <= cnt_next(short_cnt,
                lit & (analog.led_short_one | analog.led_short_two));
        end
    end

    // ****************************************
    // Flash sequencer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= flag_ctrl_pkg::ST_IDLE;
            ramp_level <= 4'h0;
            step_cnt <= 32'h0;
            tmo_cnt <= 32'h0;
        end else if (hw_off | flash_stop | timeout_hit) begin
            state <= flag_ctrl_pkg::ST_IDLE;
            ramp_level <= 4'h0;
            step_cnt <= 32'h0;
            tmo_cnt <= 32'h0;
        end else begin
            case (state)
                flag_ctrl_pkg::ST_IDLE: begin
                    if (flash_start) begin
                        state <= (target == 4'h0) ? flag_ctrl_pkg::ST_HOLD
                                                  : flag_ctrl_pkg::ST_RAMP;
                    end
                end
                flag_ctrl_pkg::ST_RAMP: begin
                    tmo_cnt <= tmo_cnt + 32'h1;
                    if (step_cnt == 32'(STEP_CYCLES - 1)) begin
                        step_cnt <= 32'h0;
                        ramp_level <= ramp_level + 4'h1;
                        if (ramp_level + 4'h1 >= target) state <= flag_ctrl_pkg::ST_HOLD;
                    end else begin
                        step_cnt <= step_cnt + 32'h1;
                    end
                end
                flag_ctrl_pkg::ST_HOLD: begin
                    tmo_cnt <= tmo_cnt + 32'h1;
                    ramp_level <= target;
                end
                default: state <= flag_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Drive outputs
    // ****************************************
    wire [3:0] torch_level = {1'b0, torch_reg[`TORCH_LVL_MSB:`TORCH_LVL_LSB]};
    wire vout_mode = mode[`MODE_MSB] | (~sync2_mode & voltage_mode_pin);
    wire led_on_next = lit & ~ot_shutdown & ~force_off;
    wire [3:0] level_next = (flash_active & ~force_torch) ? ramp_level : torch_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive <= '0;
        end else begin
            drive.led_drive_on <= led_on_next;
            drive.led_level <= led_on_next ? level_next : 4'h0;
            drive.boost_enable <= (lit | vout_mode) & ~ot_shutdown & ~hw_off;
            drive.indicator_driver <= (mode[1:0] == 2'h1) & ~therm_mode & ~ot_shutdown;
            drive.voltage_output_select <= vout_mode & ~hw_off;
            drive.output_level_select <= cfg1[`CFG1_OUT_LVL];
            // Light-load only helps in voltage mode; LED modes keep fixed frequency
            drive.light_load_enable <= vout_mode & ~lit & ~cfg1[`CFG1_LL_DIS];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_sync1_flag;
        sync1_mode & pa_sync_input_one & ~sync1_d & hardware_enable_pin |=> flags[`FLG_SYNC1];
    endproperty
    a_sync1_flag: assert property (p_sync1_flag) else $error("sync one flag not set");

    property p_sync2_flag;
        sync2_mode & sync2_event & hardware_enable_pin |=> flags[`FLG_SYNC2];
    endproperty
    a_sync2_flag: assert property (p_sync2_flag) else $error("sync two flag not set");

    property p_ot_stop;
        analog.over_temp_hot |=> ##1 !drive.led_drive_on && !drive.boost_enable;
    endproperty
    a_ot_stop: assert property (p_ot_stop) else $error("over-temperature did not stop drive");

    property p_ot_restart;
        ot_shutdown && !analog.over_temp_hot && analog.over_temp_cool |=> !ot_shutdown;
    endproperty
    a_ot_restart: assert property (p_ot_restart) else $error("no restart after cooling");

    property p_flag_hold;
        hardware_enable_pin && !flags_rd && !flash_start |=> (flags & $past(flags)) == $past(flags);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a read");

    property p_short_delay;
        // Either output may short; a pending open count would also raise the flag
        lit && (analog.led_short_one || analog.led_short_two) && !flags[`FLG_LED_FAULT_FLAG]
            && short_cnt == 32'h0 && open_cnt == 32'h0 |-> !flags[`FLG_LED_FAULT_FLAG] [*8];
    endproperty
    a_short_delay: assert property (p_short_delay) else $error("short flagged too early");

    property p_timeout_flag;
        timeout_hit && hardware_enable_pin |=> flags[`FLG_TIMEOUT] && state == flag_ctrl_pkg::ST_IDLE;
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("timeout not flagged");

    property p_early_end;
        flash_active && flash_stop |=> state == flag_ctrl_pkg::ST_IDLE;
    endproperty
    a_early_end: assert property (p_early_end) else $error("flash did not end");

    property p_start;
        !flash_active && flash_start && hardware_enable_pin && !flash_stop |=> flash_active;
    endproperty
    a_start: assert property (p_start) else $error("flash did not start");

    property p_read_keep;
        flags_rd && flag_set[`FLG_SYNC1] && hardware_enable_pin |=> flags[`FLG_SYNC1];
    endproperty
    a_read_keep: assert property (p_read_keep) else $error("event lost during read");

    property p_light_load;
        cfg1[`CFG1_LL_DIS] |=> !drive.light_load_enable;
    endproperty
    a_light_load: assert property (p_light_load) else $error("light load not disabled");

    property p_ot_flag;
        analog.over_temp_hot && !ot_shutdown && hardware_enable_pin |=> flags[`FLG_OVT];
    endproperty
    a_ot_flag: assert property (p_ot_flag) else $error("over-temperature not flagged");

    property p_hw_clear;
        !hardware_enable_pin |=> flags == `RST_FLAGS && state == flag_ctrl_pkg::ST_IDLE;
    endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("enable low did not clear");

    // Each completed step interval must raise the level by exactly one
    property p_ramp_step;
        state == flag_ctrl_pkg::ST_RAMP && step_cnt == 32'(STEP_CYCLES - 1)
            && hardware_enable_pin && !flash_stop && !timeout_hit
            |=> ramp_level == $past(ramp_level) + 4'h1;
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp step missed");

    property p_therm_flag;
        lit && therm_mode && analog.thermistor_below_ref && hardware_enable_pin
            |=> flags[`FLG_THERM];
    endproperty
    a_therm_flag: assert property (p_therm_flag) else $error("thermistor trip not flagged");

    property p_vin_flag;
        vin_mon[`VIN_MON_EN] && analog.vin_below_threshold && hardware_enable_pin
            |=> flags[`FLG_VIN];
    endproperty
    a_vin_flag: assert property (p_vin_flag) else $error("supply monitor not flagged");

endmodule : fault_flag_and_mode_control

/* File: hdl/flag_ctrl_map.svh */
// Register map, field positions, reset values and timing for the flag and mode block.
// Assumes a 125 MHz pclk and APB byte addresses equal to the register offsets.
`ifndef FLAG_CTRL_MAP_SVH
`define FLAG_CTRL_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_VIN_MON 8'h80
`define ADDR_TORCH 8'ha0
`define ADDR_FLASH 8'hb0
`define ADDR_TIMING 8'hc0
`define ADDR_FLAGS 8'hd0
`define ADDR_CFG1 8'he0
`define ADDR_CFG2 8'hf0

// ****************************************
// Reset values
// ****************************************
`define RST_VIN_MON 8'hf0
`define RST_TORCH 8'h50
`define RST_FLASH 8'h68
`define RST_TIMING 8'h4f
`define RST_FLAGS 8'h40
`define RST_CFG1 8'h42
`define RST_CFG2 8'hf0

// ****************************************
// Field positions
// ****************************************
`define FLG_TIMEOUT 0
`define FLG_OVT 1
`define FLG_LED_FAULT_FLAG 2
`define FLG_SYNC1 3
`define FLG_SYNC2 4
`define FLG_THERM 5
`define FLG_VIN 6
`define MODE_MSB 2
`define EN_FLASH 2'h3
`define FLASH_LVL_MSB 6
`define FLASH_LVL_LSB 3
`define TORCH_LVL_MSB 5
`define TORCH_LVL_LSB 3
`define FLASH_TERM_SEL 7
`define CFG1_LL_DIS 0
`define CFG1_OUT_LVL 1
`define CFG1_THERM_MODE 3
`define CFG1_SYNC2_MODE 5
`define CFG1_SYNC2_POL 6
`define CFG1_HW_TORCH 7
`define CFG2_SYNC2_OFF 0
`define CFG2_THERM_OFF 1
`define CFG2_VIN_OFF 3
`define VIN_MON_EN 0

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 8
`define LED_OPEN_DELAY_NS 2000
`define LED_SHORT_DELAY_NS 250000
`define RAMP_STEP_NS 16000
`define FLASH_TIMEOUT_NS 1000000

`endif

/* File: hdl/flag_ctrl_pkg.sv */
// Types shared by the flag and mode block.
// Assumes the map header for all numbers.
package flag_ctrl_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RAMP = 2'b01,
        ST_HOLD = 2'b11
    } flash_state_e;

    // Analog comparator and detector indications, synchronous to pclk
    typedef struct packed {
        logic over_temp_hot;
        logic over_temp_cool;
        logic overvoltage_trip;
        logic led_short_one;
        logic led_short_two;
        logic thermistor_below_ref;
        logic vin_below_threshold;
    } analog_status_s;

    typedef struct packed {
        logic led_drive_on;
        logic [3:0] led_level;
        logic boost_enable;
        logic indicator_driver;
        logic voltage_output_select;
        logic output_level_select;
        logic light_load_enable;
    } drive_ctrl_s;

endpackage : flag_ctrl_pkg
